// ---- hdl/cdl_regs.svh ----
// register offsets, field positions, reset values and timing counts of the current demand limiter
`ifndef CDL_REGS_SVH
`define CDL_REGS_SVH

// register indices on the plain register port
`define CDL_ADDR_CTRL 5'h00
`define CDL_ADDR_LIM1 5'h01
`define CDL_ADDR_LIMB1 5'h02
`define CDL_ADDR_LIMB2 5'h03
`define CDL_ADDR_LIM2 5'h04
`define CDL_ADDR_TORQUE 5'h05
`define CDL_ADDR_OFFSET 5'h06
`define CDL_ADDR_TIMER 5'h07
`define CDL_ADDR_DEMAND 5'h08
`define CDL_ADDR_FINAL 5'h09
`define CDL_ADDR_OVRLIM 5'h0a
`define CDL_ADDR_STATUS 5'h0b

// control register field positions
`define CDL_CTRL_LIM2_SEL 0
`define CDL_CTRL_OFS_SEL 1
`define CDL_CTRL_MODE_LO 2
`define CDL_CTRL_QEN_LO 4
`define CDL_CTRL_AUTO_EN 8

// full scale and reset values
`define CDL_FULL 10'h3e8
`define CDL_FULL_S 16'sh03e8
`define CDL_RST_LIM 10'h3e8
`define CDL_RST_TORQUE 11'h000
`define CDL_RST_OFFSET 11'h000
`define CDL_RST_TIMER 8'h00
`define CDL_QEN_4Q 4'hf
`define CDL_QEN_1Q 4'h1

// timing: one second tick from the 100 MHz control clock
`define CDL_CLK_NS 10
`define CDL_TICK_NS 1000000000

`endif

// ---- hdl/cdl_pkg.sv ----
// types shared by the current demand limiter
`default_nettype none
package cdl_pkg;
    typedef logic signed [10:0] cdl_dem_t;
    typedef logic [9:0] cdl_lim_t;
    typedef enum logic [1:0] {
        CDL_SPEED = 2'b00,
        CDL_TORQUE = 2'b01,
        CDL_OVERRIDE = 2'b10,
        CDL_COILER = 2'b11
    } cdl_mode_e;
    typedef enum logic [1:0] {
        CDL_T_IDLE = 2'b00,
        CDL_T_COUNT = 2'b01,
        CDL_T_DONE = 2'b10
    } cdl_tstate_e;
    typedef struct packed {
        logic auto_en;
        logic [3:0] q_en;
        cdl_mode_e mode;
        logic ofs_sel;
        logic lim2_sel;
    } cdl_ctrl_s;
endpackage
`default_nettype wire

// ---- hdl/cdl_clamp.sv ----
// signed window clamp: holds a demand between a low and a high bound
`default_nettype none
module cdl_clamp (
    input wire cdl_pkg::cdl_dem_t val,
    input wire cdl_pkg::cdl_dem_t lo,
    input wire cdl_pkg::cdl_dem_t hi,
    output cdl_pkg::cdl_dem_t res
);
    // bounds are expected ordered lo <= hi
    always_comb begin
        if (val > hi) begin
            res = hi;
        end else if (val < lo) begin
            res = lo;
        end else begin
            res = val;
        end
    end
endmodule // cdl_clamp
`default_nettype wire

// ---- hdl/cdl_top.sv ----
// current demand selection and limiting between speed loop and current loop
// Overview of operation
// - final demand leaves only after all limits
// - overriding limit is min of taper, limit two
// - limit one symmetric, taper starts from it
// - positive bridge demand clamped to its limit
// - negative bridge demand clamped to its limit
// - second limit 0 to 1000, both bridges
// - select bit one activates second limit
// - offset select adds stored offset to demand
// - two mode bits pick one of four modes
// - basic torque mode passes limited torque reference
// - override mode clamps speed output by torque
// - override motoring limits speed to speed demand
// - override regen disables torque below speed demand
// - coiler zeroes speed reference on opposing torque
// - quadrant one enable, default on
// - quadrant two enable, default by drive type
// - quadrant three enable, default by drive type
// - quadrant four enable, default by drive type
// - auto enable sets limit two select after interval
// - timer interval 0 to 255 seconds, default zero
//
// The register offsets and the address-and-strobe port were left to the implementer.
`include "cdl_regs.svh"
`default_nettype none
module cdl_top #(
    parameter bit FOUR_QUAD = 1'b1,
    parameter int TICK_CYCLES = `CDL_TICK_NS / `CDL_CLK_NS
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire cdl_pkg::cdl_dem_t speed_out,
    input wire cdl_pkg::cdl_dem_t speed_err,
    input wire cdl_pkg::cdl_dem_t speed_fb,
    input wire cdl_pkg::cdl_dem_t speed_dem,
    input wire cdl_pkg::cdl_lim_t taper_cut,
    input wire logic run_pin,
    output cdl_pkg::cdl_dem_t final_demand,
    output cdl_pkg::cdl_dem_t speed_ref_out,
    output logic zero_ref_sel
);
    // saturate a wide signed value to full scale
    function automatic cdl_pkg::cdl_dem_t sat_s(input logic signed [15:0] v);
        logic signed [15:0] m;
        m = `CDL_FULL_S;
        if (v > m) begin
            sat_s = 11'sh3e8;
        end else if (v < -m) begin
            sat_s = -11'sh3e8;
        end else begin
            sat_s = v[10:0];
        end
    endfunction

    // saturate a written unsigned limit to full scale
    function automatic cdl_pkg::cdl_lim_t sat_u(input logic [15:0] v);
        if (v > {6'h00, `CDL_FULL}) begin
            sat_u = `CDL_FULL;
        end else begin
            sat_u = v[9:0];
        end
    endfunction

    // smaller of two magnitudes
    function automatic cdl_pkg::cdl_lim_t umin(input cdl_pkg::cdl_lim_t a,
                                              input cdl_pkg::cdl_lim_t b);
        umin = (a < b) ? a : b;
    endfunction

    // magnitude of a demand, held to full scale
    function automatic cdl_pkg::cdl_lim_t mag(input cdl_pkg::cdl_dem_t v);
        logic signed [11:0] w;
        w = {v[10], v};
        if (w < 12'sh000) begin
            w = -w;
        end
        mag = sat_u({4'h0, w});
    endfunction

    // true when two values are nonzero and of opposite sign
    function automatic logic opposed(input cdl_pkg::cdl_dem_t a,
                                     input cdl_pkg::cdl_dem_t b);
        opposed = (a != 11'sh000) && (b != 11'sh000) && (a[10] != b[10]);
    endfunction

    // software registers
    cdl_pkg::cdl_ctrl_s ctrl;
    cdl_pkg::cdl_lim_t lim1;
    cdl_pkg::cdl_lim_t limb1;
    cdl_pkg::cdl_lim_t limb2;
    cdl_pkg::cdl_lim_t lim2;
    cdl_pkg::cdl_dem_t torque_ref;
    cdl_pkg::cdl_dem_t cur_offset;
    logic [7:0] timer_set;

    // datapath state
    cdl_pkg::cdl_dem_t cur_demand;
    cdl_pkg::cdl_lim_t ovr_lim;
    logic [7:0] seconds;
    logic [31:0] presc;
    cdl_pkg::cdl_tstate_e tstate;
    logic set_lim2;

    // run pin synchroniser and edge detect
    logic run_s1;
    logic run_s2;
    logic run_d;
    logic run_rise;

    // combinational datapath nets
    cdl_pkg::cdl_dem_t ovr_lo;
    cdl_pkg::cdl_dem_t ovr_hi;
    cdl_pkg::cdl_dem_t ovr_res;
    cdl_pkg::cdl_dem_t next_select;
    cdl_pkg::cdl_dem_t next_demand;
    cdl_pkg::cdl_lim_t taper_res;
    cdl_pkg::cdl_lim_t next_ovr;
    cdl_pkg::cdl_lim_t pos_lim;
    cdl_pkg::cdl_lim_t neg_lim;
    cdl_pkg::cdl_dem_t br_lo;
    cdl_pkg::cdl_dem_t br_hi;
    cdl_pkg::cdl_dem_t br_res;
    logic [3:0] quad;
    cdl_pkg::cdl_dem_t next_final;

    // run pin crosses in through two flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            run_s1 <= 1'b0;
            run_s2 <= 1'b0;
            run_d <= 1'b0;
        end else begin
            run_s1 <= run_pin;
            run_s2 <= run_s1;
            run_d <= run_s2;
        end
    end

    assign run_rise = run_s2 && !run_d;

    // control register; the timer's set beats a software clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl.lim2_sel <= 1'b0;
            ctrl.ofs_sel <= 1'b0;
            ctrl.mode <= cdl_pkg::CDL_SPEED;
            ctrl.q_en <= FOUR_QUAD ? `CDL_QEN_4Q : `CDL_QEN_1Q;
            ctrl.auto_en <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `CDL_ADDR_CTRL) begin
                ctrl.lim2_sel <= reg_wdata[`CDL_CTRL_LIM2_SEL];
                ctrl.ofs_sel <= reg_wdata[`CDL_CTRL_OFS_SEL];
                ctrl.mode <= cdl_pkg::cdl_mode_e'(reg_wdata[`CDL_CTRL_MODE_LO +: 2]);
                ctrl.q_en <= reg_wdata[`CDL_CTRL_QEN_LO +: 4];
                ctrl.auto_en <= reg_wdata[`CDL_CTRL_AUTO_EN];
            end
            if (set_lim2) begin
                ctrl.lim2_sel <= 1'b1;
            end
        end
    end

    // limit registers, writes held to 0..1000
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lim1 <= `CDL_RST_LIM;
            limb1 <= `CDL_RST_LIM;
            limb2 <= `CDL_RST_LIM;
            lim2 <= `CDL_RST_LIM;
        end else if (reg_wr) begin
            case (reg_addr)
                `CDL_ADDR_LIM1: lim1 <= sat_u(reg_wdata);
                `CDL_ADDR_LIMB1: limb1 <= sat_u(reg_wdata);
                `CDL_ADDR_LIMB2: limb2 <= sat_u(reg_wdata);
                `CDL_ADDR_LIM2: lim2 <= sat_u(reg_wdata);
                default: ;
            endcase
        end
    end

    // torque reference, offset and timer interval registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            torque_ref <= `CDL_RST_TORQUE;
            cur_offset <= `CDL_RST_OFFSET;
            timer_set <= `CDL_RST_TIMER;
        end else if (reg_wr) begin
            case (reg_addr)
                `CDL_ADDR_TORQUE: torque_ref <= sat_s(reg_wdata);
                `CDL_ADDR_OFFSET: cur_offset <= sat_s(reg_wdata);
                `CDL_ADDR_TIMER: timer_set <= reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rdata <= 16'h0000;
        end else begin
            case (reg_addr)
                `CDL_ADDR_CTRL: reg_rdata <= {7'h00, ctrl};
                `CDL_ADDR_LIM1: reg_rdata <= {6'h00, lim1};
                `CDL_ADDR_LIMB1: reg_rdata <= {6'h00, limb1};
                `CDL_ADDR_LIMB2: reg_rdata <= {6'h00, limb2};
                `CDL_ADDR_LIM2: reg_rdata <= {6'h00, lim2};
                `CDL_ADDR_TORQUE: reg_rdata <= {{5{torque_ref[10]}}, torque_ref};
                `CDL_ADDR_OFFSET: reg_rdata <= {{5{cur_offset[10]}}, cur_offset};
                `CDL_ADDR_TIMER: reg_rdata <= {8'h00, timer_set};
                `CDL_ADDR_DEMAND: reg_rdata <= {{5{cur_demand[10]}}, cur_demand};
                `CDL_ADDR_FINAL: reg_rdata <= {{5{final_demand[10]}}, final_demand};
                `CDL_ADDR_OVRLIM: reg_rdata <= {6'h00, ovr_lim};
                `CDL_ADDR_STATUS: reg_rdata <= {5'h00, zero_ref_sel, tstate, seconds};
                default: reg_rdata <= 16'h0000; // unmapped reads zero
            endcase
        end
    end

    // override window: between zero and the torque reference
    always_comb begin
        if (torque_ref[10]) begin
            ovr_lo = torque_ref;
            ovr_hi = 11'sh000;
        end else begin
            ovr_lo = 11'sh000;
            ovr_hi = torque_ref;
        end
    end

    cdl_clamp u_ovr_clamp (
        .val(speed_out),
        .lo(ovr_lo),
        .hi(ovr_hi),
        .res(ovr_res)
    );

    // demand source by mode
    always_comb begin
        case (ctrl.mode)
            cdl_pkg::CDL_SPEED: begin
                next_select = speed_out;
            end
            cdl_pkg::CDL_TORQUE: begin
                next_select = torque_ref;
            end
            cdl_pkg::CDL_OVERRIDE: begin
                // speed loop held inside torque window limits motoring speed
                next_select = ovr_res;
                if (opposed(torque_ref, speed_fb) && mag(speed_fb) < mag(speed_dem)) begin
                    next_select = 11'sh000;
                end
            end
            cdl_pkg::CDL_COILER: begin
                next_select = ovr_res;
            end
            default: begin
                next_select = speed_out;
            end
        endcase
    end

    // optional offset, saturated to full scale
    always_comb begin
        if (ctrl.ofs_sel) begin
            next_demand = sat_s({{5{next_select[10]}}, next_select}
                              + {{5{cur_offset[10]}}, cur_offset});
        end else begin
            next_demand = next_select;
        end
    end

    // overriding limit: taper from limit one, then limit two if selected
    always_comb begin
        taper_res = (taper_cut > lim1) ? 10'h000 : lim1 - taper_cut;
        if (ctrl.lim2_sel) begin
            next_ovr = umin(taper_res, lim2);
        end else begin
            next_ovr = taper_res;
        end
    end

    // per-bridge window under the overriding limit
    always_comb begin
        pos_lim = umin(ovr_lim, limb1);
        neg_lim = umin(ovr_lim, limb2);
        br_hi = cdl_pkg::cdl_dem_t'({1'b0, pos_lim});
        br_lo = -cdl_pkg::cdl_dem_t'({1'b0, neg_lim});
    end

    cdl_clamp u_br_clamp (
        .val(cur_demand),
        .lo(br_lo),
        .hi(br_hi),
        .res(br_res)
    );

    // quadrant of the limited demand against speed feedback
    always_comb begin
        quad[0] = !speed_fb[10] && !br_res[10] && br_res != 11'sh000;
        quad[1] = speed_fb[10] && !br_res[10] && br_res != 11'sh000;
        quad[2] = speed_fb[10] && br_res[10];
        quad[3] = !speed_fb[10] && br_res[10];
        if ((quad & ~ctrl.q_en) != 4'h0) begin
            next_final = 11'sh000;
        end else begin
            next_final = br_res;
        end
    end

    // demand and limit pipeline
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cur_demand <= 11'sh000;
            ovr_lim <= `CDL_RST_LIM;
            final_demand <= 11'sh000;
        end else begin
            cur_demand <= next_demand;
            ovr_lim <= next_ovr;
            final_demand <= next_final;
        end
    end

    // coiler speed reference substitution
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            zero_ref_sel <= 1'b0;
            speed_ref_out <= 11'sh000;
        end else if (ctrl.mode == cdl_pkg::CDL_COILER && opposed(torque_ref, speed_fb)) begin
            zero_ref_sel <= 1'b1;
            speed_ref_out <= 11'sh000;
        end else begin
            zero_ref_sel <= 1'b0;
            speed_ref_out <= speed_dem;
        end
    end

    // one second prescaler, restarted by each run command
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            presc <= 32'h0000_0000;
            seconds <= 8'h00;
        end else if (run_rise) begin
            presc <= 32'h0000_0000;
            seconds <= 8'h00;
        end else if (tstate == cdl_pkg::CDL_T_COUNT) begin
            if (presc == 32'(TICK_CYCLES - 1)) begin
                presc <= 32'h0000_0000;
                if (seconds != 8'hff) begin
                    seconds <= seconds + 8'h01;
                end
            end else begin
                presc <= presc + 32'h0000_0001;
            end
        end
    end

    // automatic limit two change sequencing
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tstate <= cdl_pkg::CDL_T_IDLE;
        end else begin
            case (tstate)
                cdl_pkg::CDL_T_IDLE: begin
                    if (run_rise && ctrl.auto_en) begin
                        tstate <= cdl_pkg::CDL_T_COUNT;
                    end
                end
                cdl_pkg::CDL_T_COUNT: begin
                    if (!ctrl.auto_en || !run_s2) begin
                        tstate <= cdl_pkg::CDL_T_IDLE;
                    end else if (seconds >= timer_set) begin
                        tstate <= cdl_pkg::CDL_T_DONE;
                    end
                end
                cdl_pkg::CDL_T_DONE: begin
                    if (run_rise && ctrl.auto_en) begin
                        tstate <= cdl_pkg::CDL_T_COUNT;
                    end
                end
                default: begin
                    tstate <= cdl_pkg::CDL_T_IDLE;
                end
            endcase
        end
    end

    // pulse that sets the limit two select when the interval expires
    assign set_lim2 = (tstate == cdl_pkg::CDL_T_COUNT) && ctrl.auto_en && run_s2
                      && !run_rise && (seconds >= timer_set);
endmodule // cdl_top
`default_nettype wire

// ---- test/cdl_loop_model.sv ----
// speed loop stand-in that feeds the current demand limiter
`default_nettype none
module cdl_loop_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire cdl_pkg::cdl_dem_t dem_set,
    input wire cdl_pkg::cdl_dem_t fb_set,
    input wire cdl_pkg::cdl_dem_t speed_ref_in,
    output var cdl_pkg::cdl_dem_t speed_out,
    output var cdl_pkg::cdl_dem_t speed_err,
    output var cdl_pkg::cdl_dem_t speed_fb,
    output var cdl_pkg::cdl_dem_t speed_dem
);
    timeunit 1ns;
    timeprecision 1ns;
    logic signed [11:0] err;
    // error against the reference that the limiter hands back, so coiler zeroing acts
    assign err = {speed_ref_in[10], speed_ref_in} - {speed_fb[10], speed_fb};
    // unity gain loop, one cycle of latency like a sampled controller
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            speed_dem <= '0;
            speed_fb <= '0;
            speed_err <= '0;
            speed_out <= '0;
        end else begin
            speed_dem <= dem_set;
            speed_fb <= fb_set;
            speed_err <= err[10:0];
            speed_out <= err[10:0]; // small test values never exceed full scale
        end
    end
endmodule // cdl_loop_model
`default_nettype wire

// ---- test/cdl_top_checker.sv ----
// port-level assertions for the current demand limiter
`default_nettype none
module cdl_top_checker #(
    parameter bit FOUR_QUAD = 1'b1,
    parameter int TICK_CYCLES = 10
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire cdl_pkg::cdl_dem_t speed_dem,
    input wire cdl_pkg::cdl_dem_t final_demand,
    input wire cdl_pkg::cdl_dem_t speed_ref_out,
    input wire logic zero_ref_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    // demand handed on never leaves full scale
    AST_FINAL_RANGE: assert property (final_demand >= -11'sd1000 && final_demand <= 11'sd1000)
        else $error("final demand out of range");
    // read data only in the cycle after a read strobe
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
    AST_UNMAPPED: assert property (reg_rd && reg_addr > 5'h0b |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    // final demand register mirrors the output
    AST_FINAL_READ: assert property (reg_rd && reg_addr == 5'h09 ##1 $stable(final_demand)
        |-> reg_rdata == {{5{final_demand[10]}}, final_demand})
        else $error("final demand readback wrong");
    // limits keep an in-range setting
    AST_LIM_KEEP: assert property (reg_wr && reg_addr inside {[5'h01:5'h04]} && reg_wdata <= 16'h03e8
        ##1 !reg_wr ##1 reg_rd && reg_addr == $past(reg_addr, 2)
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("limit readback wrong");
    AST_LIM_SAT: assert property (reg_wr && reg_addr inside {[5'h01:5'h04]} && reg_wdata > 16'h03e8
        ##1 !reg_wr ##1 reg_rd && reg_addr == $past(reg_addr, 2) |=> reg_rdata == 16'h03e8)
        else $error("limit not saturated");
    AST_TIMER_LOW: assert property (reg_wr && reg_addr == 5'h07 ##1 !reg_wr
        ##1 reg_rd && reg_addr == 5'h07 |=> reg_rdata == ($past(reg_wdata, 3) & 16'h00ff))
        else $error("timer readback wrong");
    // coiler substitution of the speed reference
    AST_REF_ZERO: assert property (zero_ref_sel |-> speed_ref_out == 11'sh000)
        else $error("zero reference not applied");
    AST_REF_PASS: assert property ($past(rst_b) && !zero_ref_sel
        |-> speed_ref_out == $past(speed_dem))
        else $error("speed reference not passed");
endmodule // cdl_top_checker
bind cdl_top cdl_top_checker #(.FOUR_QUAD(FOUR_QUAD), .TICK_CYCLES(TICK_CYCLES)) u_cdl_top_checker (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .speed_dem(speed_dem), .final_demand(final_demand),
    .speed_ref_out(speed_ref_out), .zero_ref_sel(zero_ref_sel));
`default_nettype wire

// ---- test/tb_cdl_top.sv ----
// self-checking bench for the current demand limiter
`default_nettype none
module tb_cdl_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    cdl_pkg::cdl_dem_t speed_out, speed_err, speed_fb, speed_dem, final_demand, speed_ref_out;
    cdl_pkg::cdl_dem_t dem_set = 11'sh000;
    cdl_pkg::cdl_dem_t fb_set = 11'sh000;
    cdl_pkg::cdl_lim_t taper_cut = 10'h000;
    logic run_pin = 1'b0;
    logic zero_ref_sel;
    int failures = 0;
    int num_checks = 0;
    int q;
    // 100 MHz control clock
    always #5 mclk = ~mclk;
    cdl_top #(.FOUR_QUAD(1'b1), .TICK_CYCLES(10)) u_cdl_top (.mclk(mclk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .speed_out(speed_out), .speed_err(speed_err),
        .speed_fb(speed_fb), .speed_dem(speed_dem), .taper_cut(taper_cut), .run_pin(run_pin),
        .final_demand(final_demand), .speed_ref_out(speed_ref_out), .zero_ref_sel(zero_ref_sel));
    cdl_loop_model u_cdl_loop_model (.mclk(mclk), .rst_b(rst_b), .dem_set(dem_set),
        .fb_set(fb_set), .speed_ref_in(speed_ref_out), .speed_out(speed_out),
        .speed_err(speed_err), .speed_fb(speed_fb), .speed_dem(speed_dem));
    // compare and count
    task automatic chk(input string what, input logic signed [15:0] seen,
            input logic signed [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    // register bus cycles
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic signed [15:0] exp, input string what);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(what, reg_rdata, exp);
    endtask
    // speed loop inputs, then let the pipeline settle before looking at the demand
    task automatic spd(input logic signed [10:0] d, input logic signed [10:0] f);
        @(posedge mclk);
        dem_set <= d;
        fb_set <= f;
    endtask
    task automatic fin(input logic signed [15:0] exp);
        repeat (8) @(posedge mclk);
        #1;
        chk("final", final_demand, exp);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        // reset values and an unmapped place
        rd(5'h00, 16'h00f0, "ctrl");
        for (q = 1; q < 5; q++) rd(q[4:0], 16'h03e8, "limit");
        rd(5'h05, 16'h0000, "torque");
        rd(5'h06, 16'h0000, "offset");
        rd(5'h07, 16'h0000, "timer");
        rd(5'h0a, 16'h03e8, "ovr");
        rd(5'h1f, 16'h0000, "unmapped");
        // writes beyond range saturate, the timer keeps only its low byte
        wr(5'h01, 16'h0fff);
        rd(5'h01, 16'h03e8, "lim1 sat");
        wr(5'h05, 16'hf830);
        rd(5'h05, 16'hfc18, "torque sat");
        wr(5'h07, 16'h012c);
        rd(5'h07, 16'h002c, "timer low");
        // each quadrant disabled in turn, then enabled, in torque mode
        for (q = 0; q < 4; q++) begin
            spd(0, (q == 0 || q == 3) ? 50 : -50);
            wr(5'h05, (q < 2) ? 16'h0064 : 16'hff9c);
            wr(5'h00, 16'h00f4 & ~(16'h0010 << q));
            fin(0);
            wr(5'h00, 16'h00f4);
            fin((q < 2) ? 100 : -100);
        end
        // bridge limits
        wr(5'h02, 16'h00c8);
        wr(5'h05, 16'h01f4);
        spd(0, 50);
        fin(200);
        wr(5'h03, 16'h012c);
        wr(5'h05, 16'hfd44);
        spd(0, -50);
        fin(-300);
        wr(5'h02, 16'h03e8);
        wr(5'h03, 16'h03e8);
        // overriding limit from limit one, taper and limit two
        spd(0, 50);
        wr(5'h05, 16'h0320);
        wr(5'h01, 16'h0258);
        rd(5'h01, 16'h0258, "lim1");
        fin(600);
        @(posedge mclk);
        taper_cut <= 10'h064;
        fin(500);
        rd(5'h0a, 16'h01f4, "ovr");
        wr(5'h04, 16'h00fa);
        wr(5'h00, 16'h00f5);
        fin(250);
        // stored offset added to the demand
        wr(5'h05, 16'h0064);
        wr(5'h06, 16'h0032);
        wr(5'h00, 16'h00f6);
        fin(150);
        rd(5'h09, 16'h0096, "final reg");
        rd(5'h08, 16'h0096, "demand reg");
        // speed mode follows the speed loop
        wr(5'h00, 16'h00f0);
        spd(300, 100);
        fin(200);
        // torque with speed override
        wr(5'h00, 16'h00f8);
        wr(5'h05, 16'h012c);
        spd(600, 100);
        fin(300);
        spd(150, 100);
        fin(50);
        spd(0, 200);
        fin(0);
        wr(5'h05, 16'hfed4);
        spd(500, 100);
        fin(0);
        spd(50, 200);
        fin(-150);
        // coiler reference substitution
        wr(5'h00, 16'h00fc);
        wr(5'h05, 16'hff38);
        spd(400, 100);
        // zero reference leaves a negative speed error, held inside the torque window
        fin(-100);
        chk("zero sel", zero_ref_sel, 1);
        chk("ref", speed_ref_out, 0);
        rd(5'h0b, 16'h0400, "status");
        wr(5'h05, 16'h00c8);
        // reference passes, speed error of 300 clamps to the torque reference
        fin(200);
        chk("zero sel", zero_ref_sel, 0);
        chk("ref", speed_ref_out, 400);
        // automatic change of limit two, off once and then restarted per run
        wr(5'h04, 16'h0064);
        wr(5'h07, 16'h0003);
        wr(5'h05, 16'h01f4);
        spd(0, 50);
        for (q = 0; q < 3; q++) begin
            wr(5'h00, (q == 0) ? 16'h00f4 : 16'h01f4);
            @(posedge mclk);
            run_pin <= 1'b1;
            repeat (20) @(posedge mclk);
            rd(5'h00, (q == 0) ? 16'h00f4 : 16'h01f4, "before");
            repeat (25) @(posedge mclk);
            rd(5'h00, (q == 0) ? 16'h00f4 : 16'h01f5, "after");
            fin((q == 0) ? 500 : 100);
            run_pin <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        conclude();
    end
endmodule // tb_cdl_top
`default_nettype wire
